// ### ttsa_pkg.sv
// package: constants, register map and carrier types of the trigger timestamp adapter
// Operation
// - slave decodes 32-bit addresses and moves 32-bit data words.
// - single reads and writes follow the bus handshake between master and slave; the code uses plain one-cycle strobes with no handshake.
// - in chained readout every module answers one shared common address.
// - each module returns a block whose length varies per event.
// - chain order is first module, intermediates, then last module.
// - an internal test trigger request can be issued besides the external one.
// - sequential mode: request while not busy becomes one 10 ns pulse to mezzanine; the code drives one 50 MHz cycle, 20 ns.
// - then accept local trigger and tag, await validation or rejection response.
// - sequential mode: data ready is set once the response has been received.
// - sequential mode: busy blocks requests until readout; busy drives pin and LED.
// - busy is set whenever a new trigger request is accepted.
// - trigger data held in registers sequentially, in RAM in pipelined mode.
// - back-pressure input from the timing network throttles accepted requests.
// - pipelined mode: busy holds until local trigger and tag are written to RAM.
// - pipelined responses go to the same RAM with a distinct marker.
package ttsa_pkg;
    // timing
    localparam int CLK_FREQ_MHZ = 50;
    localparam int TRIG_PULSE_NS = 10;
    localparam int TRIG_PULSE_RAW = (TRIG_PULSE_NS * CLK_FREQ_MHZ) / 1000;
    localparam int TRIG_PULSE_CYC = (TRIG_PULSE_RAW < 1) ? 1 : TRIG_PULSE_RAW;
    // register offsets within the module window
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_CHAIN_ADDR = 8'h10;
    localparam logic [7:0] OFS_EVT_DATA = 8'h14;
    localparam logic [7:0] OFS_EVT_COUNT = 8'h18;
    // control fields
    localparam int CTRL_PIPE_BIT = 0;
    localparam int CTRL_TEST_BIT = 1;
    localparam int CTRL_CHAIN_EN_BIT = 2;
    localparam int CTRL_FIRST_BIT = 3;
    localparam int CTRL_LAST_BIT = 4;
    localparam int CTRL_W = 5;
    localparam logic [4:0] CTRL_RST = 5'h0_0;
    // status fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_READY_BIT = 1;
    localparam int STAT_BP_BIT = 2;
    localparam int STAT_TOKEN_BIT = 3;
    // interrupt fields
    localparam int IRQ_READY_BIT = 0;
    localparam int IRQ_ACCEPT_BIT = 1;
    localparam int IRQ_OVF_BIT = 2;
    localparam int IRQ_W = 3;
    localparam logic [2:0] IRQ_RST = 3'h0;
    // response word layout: marker, pad, tag, event number; local words hold marker, pad, tag
    localparam int TAG_W = 12;
    localparam int EVN_W = 16;
    localparam logic [1:0] MRK_LOCAL = 2'h1;
    localparam logic [1:0] MRK_VALID = 2'h2;
    localparam logic [1:0] MRK_REJECT = 2'h3;
    localparam logic [31:0] WORD_EMPTY = 32'h0000_0000;
    localparam logic [31:0] WORD_END_MID = 32'hC000_0000;
    localparam logic [31:0] WORD_END_LAST = 32'hE000_0000;
    localparam logic [23:0] CHAIN_ADDR_RST = 24'h00_0000;
    // register bus request
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ttsa_bus_s;
    // responses from the timing mezzanine
    typedef struct packed {
        logic ltrig;
        logic [TAG_W-1:0] ltag;
        logic valid;
        logic [TAG_W-1:0] val_tag;
        logic [EVN_W-1:0] evnum;
        logic reject;
        logic [TAG_W-1:0] rej_tag;
    } ttsa_mezz_s;
    // trigger cycle states
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_PULSE = 5'b00010,
        ST_WAIT_LT = 5'b00100,
        ST_WAIT_RSP = 5'b01000,
        ST_READY = 5'b10000
    } ttsa_state_e;
endpackage

// ### ttsa_top.sv
// top: register slave, trigger cycle sequencer, event store and chain readout
//
// Design decisions made here: the plain strobed port and the register offsets.
module ttsa_top #(
    parameter logic [31:0] BASE_ADDR = 32'h0100_0000, // module window, upper 24 bits decoded
    parameter int DEPTH = 16 // pipelined event RAM depth
) (
    input wire logic REF_CLK, // 50 MHz clock
    input wire logic ARST_N, // async reset, active low
    input wire ttsa_pkg::ttsa_bus_s BUS, // register request
    output logic [31:0] RDATA, // read data, cycle after read strobe
    input wire logic TRIG_REQ_IN, // external trigger request level
    input wire logic BACKPRESS_IN, // throttle from timing network
    output logic TRIG_OUT, // request pulse to mezzanine
    input wire ttsa_pkg::ttsa_mezz_s MEZZ_IN, // mezzanine strobes and tags
    output logic BUSY_OUT, // front panel busy
    output logic BUSY_LED, // busy indicator
    input wire logic CHAIN_TOKEN_IN, // previous module finished its block
    output logic CHAIN_TOKEN_OUT, // our block finished
    output logic IRQ // level interrupt
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [ttsa_pkg::CTRL_W-1:0] ctrl;
        logic [23:0] chain_addr;
        logic [ttsa_pkg::IRQ_W-1:0] stat;
        logic [ttsa_pkg::IRQ_W-1:0] mask;
        ttsa_pkg::ttsa_state_e fsm;
        logic [3:0] pulse_cnt;
        logic req_q;
        logic test_pend;
        logic [31:0] w_local;
        logic [31:0] w_rsp;
        logic seq_idx;
        logic [DEPTH-1:0][31:0] ram;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic pend_v;
        logic [31:0] pend_w;
        logic busy;
        logic [31:0] rdata;
        logic irq;
        logic trig_out;
        logic token;
    } ttsa_regs_s;

    ttsa_regs_s s_ff, nxt_s;

    // register window decode, used by the bus and the chain path
    function automatic logic hit(input logic [31:0] a, input logic [23:0] base);
        hit = (a[31:8] == base);
    endfunction

    // response word builder
    function automatic logic [31:0] rsp_word(input logic [1:0] mrk, input logic [ttsa_pkg::TAG_W-1:0] tag,
                                             input logic [ttsa_pkg::EVN_W-1:0] evn);
        rsp_word = {mrk, 2'h0, tag, evn};
    endfunction

    logic pipe, chain_en, my_turn, ind_hit, com_hit, req_rise, accept, pop, rd_evt;
    logic ram_wr, ram_full;
    logic [31:0] ram_wd;
    logic [ttsa_pkg::IRQ_W-1:0] ev;

    // next state of everything
    always_comb begin
        nxt_s = s_ff;
        ev = '0;
        pipe = s_ff.ctrl[ttsa_pkg::CTRL_PIPE_BIT];
        chain_en = s_ff.ctrl[ttsa_pkg::CTRL_CHAIN_EN_BIT];
        ind_hit = hit(BUS.addr, BASE_ADDR[31:8]);
        com_hit = chain_en && hit(BUS.addr, s_ff.chain_addr);
        my_turn = s_ff.ctrl[ttsa_pkg::CTRL_FIRST_BIT] || CHAIN_TOKEN_IN;
        rd_evt = BUS.rd && ((ind_hit && BUS.addr[7:0] == ttsa_pkg::OFS_EVT_DATA) || com_hit);
        pop = 1'b0;
        ram_wr = 1'b0;
        ram_wd = ttsa_pkg::WORD_EMPTY;
        ram_full = (s_ff.cnt == (AW+1)'(DEPTH));

        // trigger request edge, internal test trigger held until taken
        nxt_s.req_q = TRIG_REQ_IN;
        req_rise = TRIG_REQ_IN && !s_ff.req_q;
        if (BUS.wr && ind_hit && BUS.addr[7:0] == ttsa_pkg::OFS_CTRL && BUS.wdata[ttsa_pkg::CTRL_TEST_BIT]) begin
            nxt_s.test_pend = 1'b1;
        end
        accept = (s_ff.fsm == ttsa_pkg::ST_IDLE) && (req_rise || s_ff.test_pend) && !BACKPRESS_IN
                 && !(pipe && s_ff.cnt >= (AW+1)'(DEPTH - 2));

        // trigger cycle sequencer
        unique case (s_ff.fsm)
            ttsa_pkg::ST_IDLE: begin
                if (accept) begin
                    nxt_s.fsm = ttsa_pkg::ST_PULSE;
                    nxt_s.trig_out = 1'b1;
                    nxt_s.pulse_cnt = 4'(ttsa_pkg::TRIG_PULSE_CYC - 1);
                    nxt_s.test_pend = 1'b0;
                    ev[ttsa_pkg::IRQ_ACCEPT_BIT] = 1'b1;
                end
            end
            ttsa_pkg::ST_PULSE: begin
                if (s_ff.pulse_cnt == 4'h0) begin
                    nxt_s.trig_out = 1'b0;
                    nxt_s.fsm = ttsa_pkg::ST_WAIT_LT;
                end else begin
                    nxt_s.pulse_cnt = s_ff.pulse_cnt - 4'h1;
                end
            end
            ttsa_pkg::ST_WAIT_LT: begin
                if (MEZZ_IN.ltrig) begin
                    nxt_s.w_local = {ttsa_pkg::MRK_LOCAL, 18'h0_0000, MEZZ_IN.ltag};
                    if (pipe) begin
                        ram_wr = 1'b1;
                        ram_wd = {ttsa_pkg::MRK_LOCAL, 18'h0_0000, MEZZ_IN.ltag};
                        nxt_s.fsm = ttsa_pkg::ST_IDLE;
                    end else begin
                        nxt_s.fsm = ttsa_pkg::ST_WAIT_RSP;
                    end
                end
            end
            ttsa_pkg::ST_WAIT_RSP: begin
                if (MEZZ_IN.valid || MEZZ_IN.reject) begin
                    nxt_s.w_rsp = MEZZ_IN.valid
                        ? rsp_word(ttsa_pkg::MRK_VALID, MEZZ_IN.val_tag, MEZZ_IN.evnum)
                        : rsp_word(ttsa_pkg::MRK_REJECT, MEZZ_IN.rej_tag, 16'h0000);
                    nxt_s.fsm = ttsa_pkg::ST_READY;
                    nxt_s.seq_idx = 1'b0;
                    ev[ttsa_pkg::IRQ_READY_BIT] = 1'b1;
                end
            end
            ttsa_pkg::ST_READY: begin
                if (pipe) begin
                    nxt_s.fsm = ttsa_pkg::ST_IDLE; // mode change abandons a held event
                end
            end
        endcase

        // pipelined responses: staged in a pending word, written when the port is free
        if (pipe) begin
            if (!ram_wr && s_ff.pend_v) begin
                ram_wr = 1'b1;
                ram_wd = s_ff.pend_w;
                nxt_s.pend_v = 1'b0;
                ev[ttsa_pkg::IRQ_READY_BIT] = 1'b1;
            end
            if (MEZZ_IN.valid || MEZZ_IN.reject) begin
                if (nxt_s.pend_v) begin
                    ev[ttsa_pkg::IRQ_OVF_BIT] = 1'b1; // pending word still occupied
                end else begin
                    nxt_s.pend_v = 1'b1;
                    nxt_s.pend_w = MEZZ_IN.valid
                        ? rsp_word(ttsa_pkg::MRK_VALID, MEZZ_IN.val_tag, MEZZ_IN.evnum)
                        : rsp_word(ttsa_pkg::MRK_REJECT, MEZZ_IN.rej_tag, 16'h0000);
                end
            end
        end

        // event readout: individual address or the chain common address
        nxt_s.rdata = ttsa_pkg::WORD_EMPTY;
        if (rd_evt && (!com_hit || my_turn)) begin
            if (!pipe && s_ff.fsm == ttsa_pkg::ST_READY) begin
                nxt_s.rdata = s_ff.seq_idx ? s_ff.w_rsp : s_ff.w_local;
                nxt_s.seq_idx = !s_ff.seq_idx;
                if (s_ff.seq_idx) begin
                    nxt_s.fsm = ttsa_pkg::ST_IDLE;
                end
            end else if (pipe && s_ff.cnt != '0) begin
                pop = 1'b1;
                nxt_s.rdata = s_ff.ram[s_ff.rp];
                nxt_s.rp = s_ff.rp + AW'(1);
            end else if (com_hit) begin
                nxt_s.rdata = s_ff.ctrl[ttsa_pkg::CTRL_LAST_BIT] ? ttsa_pkg::WORD_END_LAST
                                                                  : ttsa_pkg::WORD_END_MID;
                nxt_s.token = 1'b1;
            end
        end
        if (ev[ttsa_pkg::IRQ_READY_BIT]) begin
            nxt_s.token = 1'b0; // a new event restarts the chain pass
        end

        // RAM write with overflow guard
        if (ram_wr) begin
            if (ram_full && !pop) begin
                ev[ttsa_pkg::IRQ_OVF_BIT] = 1'b1;
                ram_wr = 1'b0;
            end else begin
                nxt_s.ram[s_ff.wp] = ram_wd;
                nxt_s.wp = s_ff.wp + AW'(1);
            end
        end
        nxt_s.cnt = s_ff.cnt + (AW+1)'(ram_wr) - (AW+1)'(pop);

        // register writes
        if (BUS.wr && ind_hit) begin
            unique case (BUS.addr[7:0])
                ttsa_pkg::OFS_CTRL: nxt_s.ctrl = BUS.wdata[ttsa_pkg::CTRL_W-1:0] & ~5'h0_2;
                ttsa_pkg::OFS_IRQ_STAT: nxt_s.stat = s_ff.stat & ~BUS.wdata[ttsa_pkg::IRQ_W-1:0];
                ttsa_pkg::OFS_IRQ_MASK: nxt_s.mask = BUS.wdata[ttsa_pkg::IRQ_W-1:0];
                ttsa_pkg::OFS_CHAIN_ADDR: nxt_s.chain_addr = BUS.wdata[31:8];
                default: ;
            endcase
        end
        nxt_s.stat = nxt_s.stat | ev; // set wins over clear

        // register reads; event data handled above
        if (BUS.rd && ind_hit && !rd_evt) begin
            unique case (BUS.addr[7:0])
                ttsa_pkg::OFS_CTRL: nxt_s.rdata = 32'(s_ff.ctrl);
                ttsa_pkg::OFS_STATUS: nxt_s.rdata = 32'({s_ff.token, BACKPRESS_IN,
                    (pipe ? (s_ff.cnt != '0) : (s_ff.fsm == ttsa_pkg::ST_READY)), s_ff.busy});
                ttsa_pkg::OFS_IRQ_STAT: nxt_s.rdata = 32'(s_ff.stat);
                ttsa_pkg::OFS_IRQ_MASK: nxt_s.rdata = 32'(s_ff.mask);
                ttsa_pkg::OFS_CHAIN_ADDR: nxt_s.rdata = {s_ff.chain_addr, 8'h00};
                ttsa_pkg::OFS_EVT_COUNT: nxt_s.rdata = 32'(s_ff.cnt);
                default: nxt_s.rdata = ttsa_pkg::WORD_EMPTY;
            endcase
        end

        // busy follows the sequencer; interrupt from new status and mask
        nxt_s.busy = (nxt_s.fsm != ttsa_pkg::ST_IDLE);
        nxt_s.irq = |(nxt_s.stat & nxt_s.mask);
    end

    // state register
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s_ff <= '0;
            s_ff.ctrl <= ttsa_pkg::CTRL_RST;
            s_ff.chain_addr <= ttsa_pkg::CHAIN_ADDR_RST;
            s_ff.stat <= ttsa_pkg::IRQ_RST;
            s_ff.mask <= ttsa_pkg::IRQ_RST;
            s_ff.fsm <= ttsa_pkg::ST_IDLE;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from the state register
    assign RDATA = s_ff.rdata;
    assign TRIG_OUT = s_ff.trig_out;
    assign BUSY_OUT = s_ff.busy;
    assign BUSY_LED = s_ff.busy;
    assign CHAIN_TOKEN_OUT = s_ff.token;
    assign IRQ = s_ff.irq;

    // request pulse is exactly one cycle wide
    pulse_width_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        $rose(TRIG_OUT) |=> !TRIG_OUT)
        else $error("trigger pulse wider than one cycle");

    // accepted request raises busy next cycle
    accept_busy_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        s_ff.fsm == ttsa_pkg::ST_IDLE && $rose(nxt_s.trig_out) |=> BUSY_OUT && TRIG_OUT)
        else $error("busy not set on accepted request");

    // sequential response makes data ready
    seq_ready_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        !pipe && s_ff.fsm == ttsa_pkg::ST_WAIT_RSP && (MEZZ_IN.valid || MEZZ_IN.reject)
        |=> s_ff.fsm == ttsa_pkg::ST_READY ##0 s_ff.stat[ttsa_pkg::IRQ_READY_BIT])
        else $error("data ready missing after response");

    // no pulse while an event waits for readout
    busy_block_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        s_ff.fsm == ttsa_pkg::ST_READY |=> !$rose(TRIG_OUT))
        else $error("request passed while busy");

    // back pressure holds off acceptance
    bp_block_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        BACKPRESS_IN && !BUSY_OUT |=> !TRIG_OUT)
        else $error("request accepted under back pressure");

    // pipelined busy drops once local trigger is stored
    pipe_release_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        pipe && s_ff.fsm == ttsa_pkg::ST_WAIT_LT && MEZZ_IN.ltrig && !ram_full
        |=> !BUSY_OUT && s_ff.cnt == $past(s_ff.cnt) + (AW+1)'(1) - (AW+1)'($past(pop)))
        else $error("busy held after local trigger stored");

    // staged validation words carry their own marker
    rsp_marker_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        pipe && MEZZ_IN.valid && !s_ff.pend_v |=> s_ff.pend_v && s_ff.pend_w[31:30] == ttsa_pkg::MRK_VALID)
        else $error("validation entry lacks its marker");

    // second event word read ends the event
    readout_done_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        !pipe && s_ff.fsm == ttsa_pkg::ST_READY && s_ff.seq_idx && rd_evt && (!com_hit || my_turn)
        |=> !BUSY_OUT && RDATA == $past(s_ff.w_rsp))
        else $error("busy not released after readout");

    // status read returns busy in the next cycle
    bus_read_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        BUS.rd && ind_hit && BUS.addr[7:0] == ttsa_pkg::OFS_STATUS
        |=> RDATA[ttsa_pkg::STAT_BUSY_BIT] == $past(BUSY_OUT))
        else $error("status read data wrong");

    // interrupt level tracks unmasked status
    irq_level_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        IRQ == |(s_ff.stat & s_ff.mask))
        else $error("interrupt level disagrees with status");
endmodule

// ### ttsa_mezz_model.sv
// mezzanine model: answers each request pulse with local trigger, tag and response
module ttsa_mezz_model (
    input wire logic clk, // system clock
    input wire logic arst_n, // async reset, active low
    input wire logic trig, // request pulse from the adapter
    input wire logic rej_sel, // answer with rejection instead of validation
    input wire logic [7:0] lt_dly, // extra cycles before local trigger
    input wire logic [7:0] rsp_dly, // cycles between local trigger and response
    output ttsa_pkg::ttsa_mezz_s mezz // strobes and tags
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] tag = 12'h0A0;
    // one request at a time; idle tag lines show the inverse of the last value
    initial begin
        mezz = '0;
        forever begin
            @(posedge clk);
            if (arst_n === 1'b1 && trig === 1'b1) begin
                repeat (lt_dly) @(posedge clk);
                mezz.ltrig <= 1'b1;
                mezz.ltag <= tag;
                @(posedge clk);
                mezz.ltrig <= 1'b0;
                mezz.ltag <= ~tag;
                repeat (rsp_dly) @(posedge clk);
                mezz.valid <= !rej_sel;
                mezz.reject <= rej_sel;
                mezz.val_tag <= tag;
                mezz.rej_tag <= tag;
                mezz.evnum <= {4'h1, tag};
                @(posedge clk);
                mezz.valid <= 1'b0;
                mezz.reject <= 1'b0;
                mezz.val_tag <= ~tag;
                mezz.rej_tag <= ~tag;
                mezz.evnum <= ~{4'h1, tag};
                tag = tag + 12'h001;
            end
        end
    end
endmodule

// ### ttsa_top_tb.sv
// self-checking bench of the trigger timestamp adapter against a mezzanine model
module ttsa_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] BASE = 32'h0100_0000;
    localparam logic [31:0] CHN = 32'h0200_0000;
    localparam logic [31:0] STAT = BASE | 32'(ttsa_pkg::OFS_STATUS);
    localparam logic [31:0] IRQS = BASE | 32'(ttsa_pkg::OFS_IRQ_STAT);
    localparam logic [31:0] EVT = BASE | 32'(ttsa_pkg::OFS_EVT_DATA);
    localparam logic [31:0] CNT = BASE | 32'(ttsa_pkg::OFS_EVT_COUNT);
    localparam logic [31:0] CEVT = CHN | 32'(ttsa_pkg::OFS_EVT_DATA);
    logic REF_CLK = 1'b0;
    logic ARST_N = 1'b0;
    ttsa_pkg::ttsa_bus_s BUS = '0;
    logic TRIG_REQ_IN = 1'b0;
    logic BACKPRESS_IN = 1'b0;
    logic CHAIN_TOKEN_IN = 1'b0;
    logic [31:0] RDATA;
    logic TRIG_OUT, BUSY_OUT, BUSY_LED, CHAIN_TOKEN_OUT, IRQ;
    ttsa_pkg::ttsa_mezz_s MEZZ_IN;
    logic rej_sel = 1'b0;
    logic [7:0] lt_dly = 8'h00;
    logic [7:0] rsp_dly = 8'h00;
    logic [11:0] tag = 12'h0A0;
    int errors = 0;
    int compares = 0;
    int pulses = 0;
    // clock and request pulse counter, one count per cycle high
    initial forever #10 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK) if (TRIG_OUT === 1'b1) pulses <= pulses + 1;
    ttsa_top #(.BASE_ADDR(BASE), .DEPTH(4)) ttsa_top_i (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .BUS(BUS),
        .RDATA(RDATA), .TRIG_REQ_IN(TRIG_REQ_IN), .BACKPRESS_IN(BACKPRESS_IN), .TRIG_OUT(TRIG_OUT),
        .MEZZ_IN(MEZZ_IN), .BUSY_OUT(BUSY_OUT), .BUSY_LED(BUSY_LED), .CHAIN_TOKEN_IN(CHAIN_TOKEN_IN),
        .CHAIN_TOKEN_OUT(CHAIN_TOKEN_OUT), .IRQ(IRQ));
    ttsa_mezz_model ttsa_mezz_model_i (.clk(REF_CLK), .arst_n(ARST_N), .trig(TRIG_OUT), .rej_sel(rej_sel),
        .lt_dly(lt_dly), .rsp_dly(rsp_dly), .mezz(MEZZ_IN));
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one-cycle write and read strobes; read data taken in the cycle after the strobe
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge REF_CLK);
        BUS.addr <= a;
        BUS.wdata <= d;
        BUS.wr <= 1'b1;
        @(posedge REF_CLK);
        BUS.wr <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge REF_CLK);
        BUS.addr <= a;
        BUS.rd <= 1'b1;
        @(posedge REF_CLK);
        BUS.rd <= 1'b0;
        #1 d = RDATA;
    endtask
    task automatic rc(input string n, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(n, d, e);
    endtask
    // bounded poll of a register field
    task automatic wait_reg(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        for (int i = 0; i < 40; i++) begin
            rd(a, d);
            if ((d & m) === e) return;
        end
        chk("poll timeout", d & m, e);
        close_out();
    endtask
    task automatic pulse_req();
        @(posedge REF_CLK);
        TRIG_REQ_IN <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        TRIG_REQ_IN <= 1'b0;
    endtask
    // sequential event: request, a second request while busy, response, two-word readout
    task automatic seq_event(input logic rj, input logic tst, input logic [31:0] m);
        int p0;
        logic [31:0] w1;
        p0 = pulses;
        rej_sel = rj;
        w1 = rj ? {2'b11, 2'b00, tag, 16'h0000} : {2'b10, 2'b00, tag, 4'h1, tag};
        wr(IRQS | 32'h0000_0004, m);
        if (tst) wr(BASE, 32'h0000_0002);
        else pulse_req();
        pulse_req();
        chk("request pulses", pulses - p0, 32'h0000_0001);
        chk("busy pins", {30'h0, BUSY_OUT, BUSY_LED}, 32'h0000_0003);
        wait_reg(STAT, 32'h0000_0002, 32'h0000_0002);
        rc("irq status", IRQS, 32'h0000_0003);
        chk("irq line", {31'h0, IRQ}, {31'h0, m != 32'h0});
        rc("local word", EVT, {2'b01, 18'h0_0000, tag});
        chk("busy mid readout", {31'h0, BUSY_OUT}, 32'h0000_0001);
        rc("response word", EVT, w1);
        @(posedge REF_CLK);
        rc("status after readout", STAT, 32'h0000_0000);
        wr(IRQS, 32'h0000_0007);
        rc("irq status cleared", IRQS, 32'h0000_0000);
        chk("irq line cleared", {31'h0, IRQ}, 32'h0000_0000);
        tag = tag + 12'h001;
    endtask
    // pipelined event: busy covers only the local trigger, response follows into the store
    task automatic pipe_event(input logic [31:0] ra);
        rej_sel = 1'b0;
        lt_dly = 8'h02;
        rsp_dly = 8'h06;
        pulse_req();
        wait_reg(STAT, 32'h0000_0001, 32'h0000_0000);
        rc("count after local", CNT, 32'h0000_0001);
        wait_reg(CNT, 32'hFFFF_FFFF, 32'h0000_0002);
        rc("pipe local word", ra, {2'b01, 18'h0_0000, tag});
        rc("pipe response word", ra, {2'b10, 2'b00, tag, 4'h1, tag});
        tag = tag + 12'h001;
    endtask
    initial begin
        int p0;
        repeat (8) @(posedge REF_CLK);
        #1 chk("outputs in reset", {27'h0, TRIG_OUT, BUSY_OUT, BUSY_LED, CHAIN_TOKEN_OUT, IRQ}, 32'h0);
        ARST_N <= 1'b1;
        rc("control reset", BASE, 32'h0000_0000);
        wr(32'h0300_0000, 32'h0000_001F);
        rc("control after foreign write", BASE, 32'h0000_0000);
        rc("unmapped offset", BASE | 32'h0000_0020, 32'h0000_0000);
        rc("foreign window", 32'h0300_0004, 32'h0000_0000);
        seq_event(1'b0, 1'b0, 32'h0000_0003);
        seq_event(1'b1, 1'b0, 32'h0000_0000);
        seq_event(1'b0, 1'b1, 32'h0000_0003);
        @(posedge REF_CLK) BACKPRESS_IN <= 1'b1;
        p0 = pulses;
        pulse_req();
        repeat (3) @(posedge REF_CLK);
        chk("throttled pulses", pulses - p0, 32'h0000_0000);
        rc("status throttled", STAT, 32'h0000_0004);
        @(posedge REF_CLK) BACKPRESS_IN <= 1'b0;
        wr(BASE, 32'h0000_0001);
        pipe_event(EVT);
        rc("pipe empty", EVT, 32'h0000_0000);
        wr(BASE | 32'(ttsa_pkg::OFS_CHAIN_ADDR), CHN);
        wr(BASE, 32'h0000_001D);
        pipe_event(CEVT);
        rc("last end word", CEVT, 32'hE000_0000);
        chk("token after block", {31'h0, CHAIN_TOKEN_OUT}, 32'h0000_0001);
        wr(BASE, 32'h0000_0005);
        rc("not our turn", CEVT, 32'h0000_0000);
        @(posedge REF_CLK) CHAIN_TOKEN_IN <= 1'b1;
        pipe_event(CEVT);
        chk("token cleared by event", {31'h0, CHAIN_TOKEN_OUT}, 32'h0000_0000);
        rc("middle end word", CEVT, 32'hC000_0000);
        chk("token after middle", {31'h0, CHAIN_TOKEN_OUT}, 32'h0000_0001);
        close_out();
    end
endmodule
